//--- logic/timer1_compat_compare_pwm.sv
// Purpose: Eight-bit timer with compare A, top compare and PWM, APB slave
// Assumes: Fast clock, lock and compat strap arrive as asynchronous pins
// Notes:   Zero wait state APB; registers one aligned word each
// Contract
// - With clear-on-match set, counter goes to zero cycle after match A
// - PWM mode clears counter cycle after it matches the top value
// - Outside PWM, match A: 00 off, 01 toggle, 10 low, 11 high
// - Clock select: 0 stop, 1-4 fast clock /1..8, 5-15 cpu /1..1024
// - Force strobe applies the action like a match, without a flag
// - Force strobe reads zero and does nothing in PWM mode
// - Prescaler reset strobe clears prescaler only and reads zero
// - Counter write takes effect one cycle later
// - Match only when counting to the value, never by a write
// - Match A sets the compare A flag after a sync delay
// - Clear-on-match also clears the counter on a top value match
// - Compare A flag, enable and global bit request its interrupt
// - Overflow flag, enable and global bit request its interrupt
// - Bits 7 and 0 of mask and flag registers read zero
// - Compare A flag clears on vector or one cycle after write one
// - Overflow flag sets on overflow, clears like the compare A flag
// - PLL register bits 6:3 read zero, lock read-only, compat forces
// - PWM: 10 low on match high at zero, 11 inverse, else off
// - PWM compare A writes buffered, loaded at top, reads buffer
// - PWM sets overflow flag when counter restarts from top
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "timer1_regs.svh"
module timer1_compat_compare_pwm (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fast_clk_in,
	input  wire logic        pll_lock_in,
	input  wire logic        compat_mode_in,
	input  wire logic        global_irq_en,
	input  wire logic        compare_a_vector_ack,
	input  wire logic        overflow_vector_ack,
	output logic             compare_a_irq_req,
	output logic             overflow_irq_req,
	output logic             compare_output_pin,
	output logic             compare_output_drive_n,
	output logic             fast_clock_enable_out,
	output logic             pll_enable_out
);
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic       fast_prev_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] count_reg;
	logic [7:0] cnt_wdata_reg;
	logic       cnt_wr_pend_reg;
	logic [7:0] compa_reg;
	logic [7:0] compa_buf_reg;
	logic [7:0] top_reg;
	logic       cmpa_en_reg;
	logic       ovf_en_reg;
	logic       cmpa_flag_reg;
	logic       ovf_flag_reg;
	logic       cmpa_clr_reg;
	logic       ovf_clr_reg;
	logic       low_speed_reg;
	logic       fast_clock_enable_reg;
	logic       pll_enable_reg;
	logic       force_pend_reg;
	logic       psr_pend_reg;
	logic [9:0] cpu_pre_reg;
	logic [2:0] fast_pre_reg;
	logic       match_a_reg;
	logic       top_hit_reg;
	logic       ovf_evt_reg;
	logic       wr_en;
	logic [5:0] index;
	logic [7:0] wdata;
	logic       pwm_on;
	logic       ctc_on;
	logic [3:0] clk_sel;
	logic       fast_clock_enable_eff;
	logic       pll_enable_eff;
	logic       count_tick;
	logic       tick_eff;
	logic       clear_now;
	logic [7:0] cnt_inc;
	logic [7:0] rd_byte;
	logic       rd_hit;
	timer1_pkg::compare_action_type action;

	assign index    = paddr[7:2];
	assign wdata    = pwdata[7:0];
	assign wr_en    = psel & penable & pwrite & pready;
	assign pwm_on   = ctrl_reg[`TC_PWM_ENABLE];
	assign ctc_on   = ctrl_reg[`TC_CLEAR_ON_MATCH];
	assign clk_sel  = ctrl_reg[`TC_CLOCK_SEL_HI:0];
	assign action   = timer1_pkg::compare_action_type'(
		ctrl_reg[`TC_ACTION_HI:`TC_ACTION_LO]);
	assign fast_clock_enable_eff = fast_clock_enable_reg | sync2_reg[2];
	assign pll_enable_eff = pll_enable_reg | sync2_reg[2];
	assign cnt_inc  = count_reg + 8'h01;

	// Pins: 0 fast clock, 1 lock, 2 compat strap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg     <= 3'h0;
			sync2_reg     <= 3'h0;
			fast_prev_reg <= 1'b0;
		end else begin
			sync1_reg     <= {compat_mode_in, pll_lock_in, fast_clk_in};
			sync2_reg     <= sync1_reg;
			fast_prev_reg <= sync2_reg[0];
		end
	end

	// Clock select and prescalers
	always_comb begin
		logic [10:0] cmask;
		logic [3:0]  fmask;
		cmask = (11'h001 << (clk_sel - `CS_FIRST_CPU)) - 11'h001;
		fmask = (4'h1 << (clk_sel - 4'h1)) - 4'h1;
		if (clk_sel == 4'h0)
			count_tick = 1'b0;
		else if (clk_sel < `CS_FIRST_CPU)
			count_tick = sync2_reg[0] & ~fast_prev_reg & fast_clock_enable_eff &
				((fast_pre_reg & fmask[2:0]) == fmask[2:0]);
		else
			count_tick = (cpu_pre_reg & cmask[9:0]) == cmask[9:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_pre_reg  <= 10'h000;
			fast_pre_reg <= 3'h0;
		end else if (psr_pend_reg) begin
			cpu_pre_reg  <= 10'h000;
			fast_pre_reg <= 3'h0;
		end else begin
			cpu_pre_reg <= cpu_pre_reg + 10'h001;
			if (sync2_reg[0] & ~fast_prev_reg)
				fast_pre_reg <= fast_pre_reg + 3'h1;
		end
	end

	// Clearing waits one cycle after the match, as the counter did
	assign clear_now = (match_a_reg & ctc_on) |
		(top_hit_reg & (ctc_on | pwm_on));
	assign tick_eff = count_tick & ~cnt_wr_pend_reg & ~clear_now;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg       <= `RST_BYTE;
			cnt_wr_pend_reg <= 1'b0;
			cnt_wdata_reg   <= `RST_BYTE;
		end else begin
			cnt_wr_pend_reg <= wr_en & (index == `IDX_COUNTER);
			cnt_wdata_reg   <= wdata;
			if (cnt_wr_pend_reg)
				count_reg <= cnt_wdata_reg;
			else if (clear_now)
				count_reg <= 8'h00;
			else if (tick_eff)
				count_reg <= cnt_inc;
		end
	end

	// A write never raises an event: only counting does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_a_reg <= 1'b0;
			top_hit_reg <= 1'b0;
			ovf_evt_reg <= 1'b0;
		end else begin
			match_a_reg <= tick_eff & (cnt_inc == compa_reg);
			top_hit_reg <= tick_eff & (cnt_inc == top_reg);
			ovf_evt_reg <= tick_eff & ((count_reg == 8'hff) |
				(pwm_on & (cnt_inc == top_reg)));
		end
	end

	// Compare A buffer keeps PWM pulses glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compa_reg     <= `RST_BYTE;
			compa_buf_reg <= `RST_BYTE;
		end else begin
			if (wr_en & (index == `IDX_COMPARE_A))
				compa_buf_reg <= wdata;
			if (wr_en & (index == `IDX_COMPARE_A) & ~pwm_on)
				compa_reg <= wdata;
			else if (pwm_on & top_hit_reg)
				compa_reg <= compa_buf_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg       <= `RST_BYTE;
			top_reg        <= `RST_TOP_VALUE;
			cmpa_en_reg    <= 1'b0;
			ovf_en_reg     <= 1'b0;
			low_speed_reg  <= 1'b0;
			fast_clock_enable_reg       <= 1'b0;
			pll_enable_reg       <= 1'b0;
			force_pend_reg <= 1'b0;
			psr_pend_reg   <= 1'b0;
			cmpa_clr_reg   <= 1'b0;
			ovf_clr_reg    <= 1'b0;
		end else begin
			if (wr_en & (index == `IDX_TIMER_CONTROL))
				ctrl_reg <= wdata;
			if (wr_en & (index == `IDX_TOP_VALUE))
				top_reg <= wdata;
			if (wr_en & (index == `IDX_IRQ_MASK)) begin
				cmpa_en_reg <= wdata[`IRQ_COMPARE_A];
				ovf_en_reg  <= wdata[`IRQ_OVERFLOW];
			end
			if (wr_en & (index == `IDX_PLL_CTRL_STAT)) begin
				low_speed_reg <= wdata[`PLL_LOW_SPEED];
				fast_clock_enable_reg      <= wdata[`PLL_FAST_CLK_EN];
				pll_enable_reg      <= wdata[`PLL_ENABLE];
			end
			force_pend_reg <= wr_en & (index == `IDX_GEN_TIMER_CTRL) &
				wdata[`GT_FORCE_COMPARE] & ~pwm_on;
			psr_pend_reg <= wr_en & (index == `IDX_GEN_TIMER_CTRL) &
				wdata[`GT_PRESCALER_RESET];
			cmpa_clr_reg <= wr_en & (index == `IDX_IRQ_FLAGS) &
				wdata[`IRQ_COMPARE_A];
			ovf_clr_reg <= wr_en & (index == `IDX_IRQ_FLAGS) &
				wdata[`IRQ_OVERFLOW];
		end
	end

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmpa_flag_reg     <= 1'b0;
			ovf_flag_reg      <= 1'b0;
			compare_a_irq_req <= 1'b0;
			overflow_irq_req  <= 1'b0;
		end else begin
			cmpa_flag_reg <= match_a_reg | (cmpa_flag_reg &
				~(cmpa_clr_reg | compare_a_vector_ack));
			ovf_flag_reg <= ovf_evt_reg | (ovf_flag_reg &
				~(ovf_clr_reg | overflow_vector_ack));
			compare_a_irq_req <= cmpa_flag_reg & cmpa_en_reg &
				global_irq_en;
			overflow_irq_req <= ovf_flag_reg & ovf_en_reg &
				global_irq_en;
		end
	end

	// Pin drive needs the port direction set outside this block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_output_pin     <= 1'b0;
			compare_output_drive_n <= 1'b1;
		end else begin
			compare_output_drive_n <= pwm_on ? ~action[1] :
				(action == timer1_pkg::ACT_OFF);
			if (pwm_on) begin
				if (clear_now & action[1])
					compare_output_pin <= ~action[0];
				else if (match_a_reg & action[1])
					compare_output_pin <= action[0];
			end else if (match_a_reg | force_pend_reg) begin
				unique case (action)
					timer1_pkg::ACT_OFF:    ;
					timer1_pkg::ACT_TOGGLE:
						compare_output_pin <= ~compare_output_pin;
					timer1_pkg::ACT_CLEAR:
						compare_output_pin <= 1'b0;
					timer1_pkg::ACT_SET:
						compare_output_pin <= 1'b1;
				endcase
			end
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		unique case (index)
			`IDX_TIMER_CONTROL:  rd_byte = ctrl_reg;
			`IDX_GEN_TIMER_CTRL: rd_byte = 8'h00;
			`IDX_COUNTER:        rd_byte = count_reg;
			`IDX_COMPARE_A:      rd_byte = compa_buf_reg;
			`IDX_TOP_VALUE:      rd_byte = top_reg;
			`IDX_IRQ_MASK:
				rd_byte = {1'b0, cmpa_en_reg, 3'b000, ovf_en_reg,
					2'b00};
			`IDX_IRQ_FLAGS:
				rd_byte = {1'b0, cmpa_flag_reg, 3'b000, ovf_flag_reg,
					2'b00};
			`IDX_PLL_CTRL_STAT:
				rd_byte = {low_speed_reg, 4'h0, fast_clock_enable_eff, pll_enable_eff,
					sync2_reg[1]};
			default:             rd_hit = 1'b0;
		endcase
	end

	// Answer prepared in the setup cycle, so every APB output is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata                <= 32'h0000_0000;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
			fast_clock_enable_out <= 1'b0;
			pll_enable_out        <= 1'b0;
		end else begin
			pready                <= psel & ~penable;
			pslverr               <= psel & ~penable & ~rd_hit;
			prdata                <= {24'h000000, rd_byte};
			fast_clock_enable_out <= fast_clock_enable_eff;
			pll_enable_out        <= pll_enable_eff;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ctc_clear;
		match_a_reg & ctc_on & ~cnt_wr_pend_reg |=> count_reg == 8'h00;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear)
		else $error("counter not cleared after compare A match");

	property p_pwm_clear;
		top_hit_reg & pwm_on & ~cnt_wr_pend_reg |=> count_reg == 8'h00;
	endproperty
	a_pwm_clear: assert property (p_pwm_clear)
		else $error("counter not cleared after top match in PWM");

	property p_toggle;
		~pwm_on & match_a_reg & (action == timer1_pkg::ACT_TOGGLE)
		|=> compare_output_pin != $past(compare_output_pin);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("output did not toggle on match");

	property p_force;
		force_pend_reg & ~match_a_reg & ~cmpa_flag_reg
		|=> ~cmpa_flag_reg;
	endproperty
	a_force: assert property (p_force)
		else $error("forced compare raised a flag");

	property p_psr;
		psr_pend_reg |=> cpu_pre_reg == 10'h000;
	endproperty
	a_psr: assert property (p_psr)
		else $error("prescaler not reset");

	property p_cnt_write;
		wr_en & (index == `IDX_COUNTER)
		|-> ##2 count_reg == $past(wdata, 2);
	endproperty
	a_cnt_write: assert property (p_cnt_write)
		else $error("counter write not applied on time");

	property p_no_write_match;
		cnt_wr_pend_reg |=> ~match_a_reg & ~top_hit_reg;
	endproperty
	a_no_write_match: assert property (p_no_write_match)
		else $error("counter write produced a match");

	property p_flag_a;
		match_a_reg |=> cmpa_flag_reg ##1 (compare_a_irq_req ==
			($past(cmpa_en_reg) & $past(global_irq_en)));
	endproperty
	a_flag_a: assert property (p_flag_a)
		else $error("compare A flag or request wrong");

	property p_flag_clear;
		ovf_clr_reg & ~ovf_evt_reg |=> ~ovf_flag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("overflow flag not cleared");

	property p_stopped;
		(clk_sel == 4'h0) & ~cnt_wr_pend_reg & ~clear_now
		|=> $stable(count_reg);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("stopped counter moved");

	c_ctc: cover property (match_a_reg & ctc_on);
	c_pwm_wrap: cover property (pwm_on & top_hit_reg ##1 ovf_flag_reg);
	c_force: cover property (force_pend_reg);
	c_irq: cover property (overflow_irq_req);
endmodule : timer1_compat_compare_pwm

//--- logic/timer1_pkg.sv
// Purpose: Types shared by the timer 1 design
// Assumes: Nothing
// Notes:   Compare output action codes
package timer1_pkg;
	typedef enum logic [1:0] {
		ACT_OFF    = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR  = 2'b10,
		ACT_SET    = 2'b11
	} compare_action_type;
endpackage : timer1_pkg

//--- logic/timer1_regs.svh
// Purpose: Register indices, bit positions and reset values of timer 1
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef TIMER1_REGS_SVH
`define TIMER1_REGS_SVH
`define IDX_TIMER_CONTROL   6'h30
`define IDX_PLL_CTRL_STAT   6'h27
`define IDX_GEN_TIMER_CTRL  6'h2c
`define IDX_TOP_VALUE       6'h2d
`define IDX_COMPARE_A       6'h2e
`define IDX_COUNTER         6'h2f
`define IDX_IRQ_FLAGS       6'h38
`define IDX_IRQ_MASK        6'h39
`define TC_CLEAR_ON_MATCH   7
`define TC_PWM_ENABLE       6
`define TC_ACTION_HI        5
`define TC_ACTION_LO        4
`define TC_CLOCK_SEL_HI     3
`define GT_FORCE_COMPARE    2
`define GT_PRESCALER_RESET  1
`define IRQ_COMPARE_A       6
`define IRQ_OVERFLOW        2
`define PLL_LOW_SPEED       7
`define PLL_FAST_CLK_EN     2
`define PLL_ENABLE          1
`define PLL_LOCK            0
`define RST_BYTE            8'h00
`define RST_TOP_VALUE       8'hff
`define CS_FIRST_CPU        4'h5
`endif

//--- verif/timer1_compat_compare_pwm_test.sv
// Purpose: Self-checking bench for the timer 1 block over APB
// Assumes: Zero wait state slave, byte address is four times the index
// Notes:   Counts are checked inside tolerances that absorb sync delays
`timescale 1ns/1ps
module timer1_compat_compare_pwm_test;
	localparam logic [7:0] A_TC  = 8'hc0;
	localparam logic [7:0] A_PLL = 8'h9c;
	localparam logic [7:0] A_GEN = 8'hb0;
	localparam logic [7:0] A_TOP = 8'hb4;
	localparam logic [7:0] A_CMP = 8'hb8;
	localparam logic [7:0] A_CNT = 8'hbc;
	localparam logic [7:0] A_FLG = 8'he0;
	localparam logic [7:0] A_MSK = 8'he4;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, fast_clk_in, fast_run;
	logic        pll_lock_in, compat_mode_in, global_irq_en;
	logic        compare_a_vector_ack, overflow_vector_ack;
	logic        compare_a_irq_req, overflow_irq_req;
	logic        compare_output_pin, compare_output_drive_n;
	logic        fast_clock_enable_out, pll_enable_out;
	int          n_mismatch, compares;
	int          sel_tab [6] = '{5, 6, 7, 8, 1, 2};
	int          div_tab [6] = '{1, 2, 4, 8, 2, 4};
	timer1_compat_compare_pwm timer1_compat_compare_pwm_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fast_clk_in(fast_clk_in),
		.pll_lock_in(pll_lock_in), .compat_mode_in(compat_mode_in),
		.global_irq_en(global_irq_en),
		.compare_a_vector_ack(compare_a_vector_ack),
		.overflow_vector_ack(overflow_vector_ack),
		.compare_a_irq_req(compare_a_irq_req),
		.overflow_irq_req(overflow_irq_req),
		.compare_output_pin(compare_output_pin),
		.compare_output_drive_n(compare_output_drive_n),
		.fast_clock_enable_out(fast_clock_enable_out),
		.pll_enable_out(pll_enable_out));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Fast clock runs at half the bus rate, only while a test wants it
	always @(posedge pclk) begin
		fast_clk_in <= fast_run ? ~fast_clk_in : 1'b0;
	end
	task finish_test;
		if (n_mismatch == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : check_word
	task check_flag(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask : check_flag
	// One APB transfer; request held until pready is sampled high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h000000, d});
	endtask : wr
	task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h00000000);
		check_word(nm, {24'h000000, e}, rd);
	endtask : rd_chk
	task cyc(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask : cyc
	task pulse_ack(input logic which);
		@(posedge pclk);
		if (which) compare_a_vector_ack <= 1'b1;
		else overflow_vector_ack <= 1'b1;
		@(posedge pclk);
		compare_a_vector_ack <= 1'b0;
		overflow_vector_ack  <= 1'b0;
	endtask : pulse_ack
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		n_mismatch = 0;
		compares = 0;
		{presetn, psel, penable, pwrite, fast_run} = 5'b00000;
		{pll_lock_in, compat_mode_in, global_irq_en} = 3'b000;
		{compare_a_vector_ack, overflow_vector_ack} = 2'b00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("tc reset", A_TC, 8'h00);
		rd_chk("top reset", A_TOP, 8'hff);
		rd_chk("cnt reset", A_CNT, 8'h00);
		check_flag("drive_n reset", 1'b1, compare_output_drive_n);
		xfer(1'b0, 8'h00, 32'h00000000);
		check_flag("unmapped err", 1'b1, err);
		wr(A_MSK, 8'hff);
		rd_chk("mask reserved", A_MSK, 8'h44);
		wr(A_MSK, 8'h00);
		// PLL register: reserved bits, read-only lock, compat strap
		pll_lock_in <= 1'b1;
		cyc(2);
		rd_chk("lock seen", A_PLL, 8'h01);
		wr(A_PLL, 8'hff);
		rd_chk("pll rw", A_PLL, 8'h87);
		wr(A_PLL, 8'h00);
		compat_mode_in <= 1'b1;
		cyc(4);
		rd_chk("pll compat", A_PLL, 8'h07);
		check_flag("fast en", 1'b1, fast_clock_enable_out);
		check_flag("pll en", 1'b1, pll_enable_out);
		// Clock select rates, prescaler restarted before each run
		fast_run <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			wr(A_CNT, 8'h00);
			wr(A_GEN, 8'h02);
			wr(A_TC, sel_tab[k][7:0]);
			cyc(64);
			wr(A_TC, 8'h00);
			xfer(1'b0, A_CNT, 32'h00000000);
			check_flag("rate lo", 1'b1, rd >= 64 / div_tab[k]);
			check_flag("rate hi", 1'b1, rd <= 64 / div_tab[k] + 8);
		end
		fast_run <= 1'b0;
		rd_chk("gen reads 0", A_GEN, 8'h00);
		wr(A_CNT, 8'h10);
		wr(A_GEN, 8'h02);
		cyc(4);
		rd_chk("psr keeps cnt", A_CNT, 8'h10);
		// Clear on compare A, flag, interrupt and set action
		global_irq_en <= 1'b1;
		wr(A_FLG, 8'h44);
		wr(A_CMP, 8'h05);
		wr(A_MSK, 8'h40);
		wr(A_CNT, 8'h00);
		wr(A_TC, 8'hb5);
		cyc(30);
		wr(A_TC, 8'hb0);
		xfer(1'b0, A_CNT, 32'h00000000);
		check_flag("ctc wrap", 1'b1, rd <= 32'h5);
		rd_chk("flag a", A_FLG, 8'h40);
		check_flag("irq a", 1'b1, compare_a_irq_req);
		check_flag("pin set", 1'b1, compare_output_pin);
		check_flag("pin driven", 1'b0, compare_output_drive_n);
		pulse_ack(1'b1);
		cyc(3);
		rd_chk("ack clears a", A_FLG, 8'h00);
		check_flag("irq a off", 1'b0, compare_a_irq_req);
		// Clear on top match without reaching compare A
		wr(A_CMP, 8'h80);
		wr(A_TOP, 8'h07);
		wr(A_TC, 8'h85);
		cyc(40);
		wr(A_TC, 8'h00);
		xfer(1'b0, A_CNT, 32'h00000000);
		check_flag("top wrap", 1'b1, rd <= 32'h7);
		rd_chk("no flag a", A_FLG, 8'h00);
		// Overflow flag, interrupt, write-one clear, stopped counter
		wr(A_TOP, 8'hff);
		wr(A_MSK, 8'h04);
		wr(A_CNT, 8'hfe);
		wr(A_TC, 8'h05);
		cyc(6);
		wr(A_TC, 8'h00);
		rd_chk("ovf flag", A_FLG, 8'h04);
		check_flag("irq ovf", 1'b1, overflow_irq_req);
		xfer(1'b0, A_CNT, 32'h00000000);
		cyc(10);
		rd_chk("stop holds", A_CNT, rd[7:0]);
		wr(A_FLG, 8'h04);
		cyc(2);
		rd_chk("w1c ovf", A_FLG, 8'h00);
		wr(A_FLG, 8'h00);
		wr(A_CNT, 8'hfe);
		wr(A_TC, 8'h05);
		cyc(6);
		wr(A_TC, 8'h00);
		check_flag("irq ovf set", 1'b1, overflow_irq_req);
		pulse_ack(1'b0);
		cyc(3);
		check_flag("ack ovf", 1'b0, overflow_irq_req);
		// Force strobe outside and inside PWM mode
		wr(A_TC, 8'h20);
		wr(A_GEN, 8'h04);
		cyc(4);
		check_flag("force clr", 1'b0, compare_output_pin);
		rd_chk("no flag force", A_FLG, 8'h00);
		wr(A_TC, 8'h10);
		wr(A_GEN, 8'h04);
		cyc(4);
		check_flag("force tgl", 1'b1, compare_output_pin);
		wr(A_TC, 8'h60);
		wr(A_GEN, 8'h04);
		cyc(4);
		check_flag("force pwm", 1'b1, compare_output_pin);
		wr(A_TC, 8'h00);
		cyc(3);
		check_flag("pin off", 1'b1, compare_output_drive_n);
		// Software write equal to compare value gives no match
		wr(A_CMP, 8'h20);
		wr(A_CNT, 8'h20);
		wr(A_TC, 8'h05);
		cyc(6);
		wr(A_TC, 8'h00);
		rd_chk("write no match", A_FLG, 8'h00);
		// PWM: wrap at top, overflow at top, buffered compare A
		wr(A_TOP, 8'h09);
		wr(A_CMP, 8'h03);
		wr(A_CNT, 8'h00);
		wr(A_TC, 8'h65);
		cyc(40);
		check_flag("pwm drive", 1'b0, compare_output_drive_n);
		wr(A_CMP, 8'h07);
		rd_chk("buffer read", A_CMP, 8'h07);
		wr(A_TC, 8'h00);
		xfer(1'b0, A_CNT, 32'h00000000);
		check_flag("pwm wrap", 1'b1, rd <= 32'h9);
		rd_chk("pwm ovf", A_FLG, 8'h44);
		finish_test;
	end
endmodule : timer1_compat_compare_pwm_test
